// file: rtl/dual_counter_pkg.sv
package dual_counter_pkg;
    localparam int         COUNT_W      = 16;
    localparam int         BYTE_W       = 8;
    localparam int         SYNC_W       = 2;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_ONE   = 16'h0001;
    localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
    localparam logic [7:0]  BYTE_ZERO   = 8'h00;
    localparam logic [1:0]  SYNC_ZERO   = 2'h0;
    localparam logic [1:0]  SYNC_ONES   = 2'h3;
    localparam int         LOW_LSB      = 0;
    localparam int         HIGH_LSB     = 8;

    typedef enum {
        SEL_NONE,
        SEL_A_LOW,
        SEL_A_HIGH,
        SEL_B_LOW,
        SEL_B_HIGH
    } byte_sel_t;
endpackage : dual_counter_pkg

// file: rtl/dual_counter_snapshot_reader.sv
`timescale 1ns/1ps
module dual_counter_snapshot_reader (
    // system
    input  wire logic       I_CLK,
    input  wire logic       I_SYS_RST,
    // counter pins
    input  wire logic       I_COUNT_CLOCK_A,
    input  wire logic       I_COUNT_CLOCK_B,
    input  wire logic       I_COUNTER_B_ENABLE_N,
    input  wire logic       I_COUNTERS_ASYNC_RESET_N,
    output logic            O_COUNTER_A_TERMINAL_N,
    // snapshot and read bus
    input  wire logic       I_REGISTER_CLOCK,
    input  wire logic       I_SEL_A_LOW_BYTE_N,
    input  wire logic       I_SEL_A_HIGH_BYTE_N,
    input  wire logic       I_SEL_B_LOW_BYTE_N,
    input  wire logic       I_SEL_B_HIGH_BYTE_N,
    output logic [7:0]      O_Y,
    output logic            O_Y_OE_N
);

    logic [1:0]  clk_a_sync_reg;
    logic [1:0]  clk_b_sync_reg;
    logic [1:0]  en_b_sync_reg;
    logic [1:0]  clr_sync_reg;
    logic [1:0]  rclk_sync_reg;
    logic [1:0]  gal_sync_reg;
    logic [1:0]  gau_sync_reg;
    logic [1:0]  gbl_sync_reg;
    logic [1:0]  gbu_sync_reg;
    logic        clk_a_prev_reg;
    logic        clk_b_prev_reg;
    logic        rclk_prev_reg;
    logic [15:0] count_a_reg;
    logic [15:0] count_b_reg;
    logic [15:0] count_a_next;
    logic [15:0] count_b_next;
    logic [15:0] snap_a_reg;
    logic [15:0] snap_b_reg;
    logic        counter_clear;
    logic        rise_a;
    logic        rise_b;
    logic        rise_rclk;
    dual_counter_pkg::byte_sel_t sel;
    logic [7:0]  y_next;
    logic [15:0] snap_a_next;
    logic [15:0] snap_b_next;
    logic        term_next;
    logic        y_oe_n_next;

    function automatic logic [7:0] pick_byte(input logic [15:0] word, input int lsb);
        pick_byte = word[lsb +: dual_counter_pkg::BYTE_W];
    endfunction : pick_byte

    // prev flops reset low like the idle pins, so no false edge follows reset
    function automatic logic rising(input logic now_level, input logic prev_level);
        rising = now_level & ~prev_level;
    endfunction : rising

    function automatic logic [15:0] count_up(input logic [15:0] value);
        count_up = value + dual_counter_pkg::COUNT_ONE;
    endfunction : count_up

    // clear acts without a clock; the counters also stay held until the synced release
    assign counter_clear = I_SYS_RST | ~I_COUNTERS_ASYNC_RESET_N;

    // count clock a synchroniser
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            clk_a_sync_reg <= dual_counter_pkg::SYNC_ZERO;
        end else begin
            clk_a_sync_reg <= {clk_a_sync_reg[0], I_COUNT_CLOCK_A};
        end
    end

    // count clock b and its enable pass equal delays, so they stay aligned
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            clk_b_sync_reg <= dual_counter_pkg::SYNC_ZERO;
            en_b_sync_reg  <= dual_counter_pkg::SYNC_ONES;
        end else begin
            clk_b_sync_reg <= {clk_b_sync_reg[0], I_COUNT_CLOCK_B};
            en_b_sync_reg  <= {en_b_sync_reg[0], I_COUNTER_B_ENABLE_N};
        end
    end

    // clear release synchroniser; counting resumes only after it
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            clr_sync_reg <= dual_counter_pkg::SYNC_ZERO;
        end else begin
            clr_sync_reg <= {clr_sync_reg[0], I_COUNTERS_ASYNC_RESET_N};
        end
    end

    // register clock synchroniser
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            rclk_sync_reg <= dual_counter_pkg::SYNC_ZERO;
        end else begin
            rclk_sync_reg <= {rclk_sync_reg[0], I_REGISTER_CLOCK};
        end
    end

    // a byte gate synchronisers, reset to the released level
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            gal_sync_reg <= dual_counter_pkg::SYNC_ONES;
            gau_sync_reg <= dual_counter_pkg::SYNC_ONES;
        end else begin
            gal_sync_reg <= {gal_sync_reg[0], I_SEL_A_LOW_BYTE_N};
            gau_sync_reg <= {gau_sync_reg[0], I_SEL_A_HIGH_BYTE_N};
        end
    end

    // b byte gate synchronisers, reset to the released level
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            gbl_sync_reg <= dual_counter_pkg::SYNC_ONES;
            gbu_sync_reg <= dual_counter_pkg::SYNC_ONES;
        end else begin
            gbl_sync_reg <= {gbl_sync_reg[0], I_SEL_B_LOW_BYTE_N};
            gbu_sync_reg <= {gbu_sync_reg[0], I_SEL_B_HIGH_BYTE_N};
        end
    end

    // count clock a edge history
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            clk_a_prev_reg <= 1'b0;
        end else begin
            clk_a_prev_reg <= clk_a_sync_reg[1];
        end
    end

    // count clock b edge history
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            clk_b_prev_reg <= 1'b0;
        end else begin
            clk_b_prev_reg <= clk_b_sync_reg[1];
        end
    end

    // register clock edge history
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            rclk_prev_reg <= 1'b0;
        end else begin
            rclk_prev_reg <= rclk_sync_reg[1];
        end
    end

    assign rise_a    = rising(clk_a_sync_reg[1], clk_a_prev_reg);
    assign rise_b    = rising(clk_b_sync_reg[1], clk_b_prev_reg);
    assign rise_rclk = rising(rclk_sync_reg[1], rclk_prev_reg);

    always_comb begin
        count_a_next = count_a_reg;
        if (!clr_sync_reg[1]) begin
            count_a_next = dual_counter_pkg::COUNT_RESET;
        end else if (rise_a) begin
            count_a_next = count_up(count_a_reg);
        end
    end

    // gated counter b next
    // a chained enable arrives two cycles after the a flag, so a must not run flat out
    always_comb begin
        count_b_next = count_b_reg;
        if (!clr_sync_reg[1]) begin
            count_b_next = dual_counter_pkg::COUNT_RESET;
        end else if (rise_b && !en_b_sync_reg[1]) begin
            count_b_next = count_up(count_b_reg);
        end
    end

    always_ff @(posedge I_CLK or posedge counter_clear) begin
        if (counter_clear) begin
            count_a_reg <= dual_counter_pkg::COUNT_RESET;
        end else begin
            count_a_reg <= count_a_next;
        end
    end

    always_ff @(posedge I_CLK or posedge counter_clear) begin
        if (counter_clear) begin
            count_b_reg <= dual_counter_pkg::COUNT_RESET;
        end else begin
            count_b_reg <= count_b_next;
        end
    end

    // flag from the next count, so it changes at the same edge as the count
    always_comb begin
        term_next = (count_a_next != dual_counter_pkg::COUNT_MAX);
    end

    // terminal flag, forced high by the clear
    always_ff @(posedge I_CLK or posedge counter_clear) begin
        if (counter_clear) begin
            O_COUNTER_A_TERMINAL_N <= 1'b1;
        end else begin
            O_COUNTER_A_TERMINAL_N <= term_next;
        end
    end

    // load on each register clock rise; no clock enable, the hold is in the next value
    always_comb begin
        snap_a_next = snap_a_reg;
        snap_b_next = snap_b_reg;
        if (rise_rclk) begin
            snap_a_next = count_a_reg;
            snap_b_next = count_b_reg;
        end
    end

    // stored a count; the counter clear leaves it alone
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            snap_a_reg <= dual_counter_pkg::COUNT_RESET;
        end else begin
            snap_a_reg <= snap_a_next;
        end
    end

    // stored b count; the counter clear leaves it alone
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            snap_b_reg <= dual_counter_pkg::COUNT_RESET;
        end else begin
            snap_b_reg <= snap_b_next;
        end
    end

    // gate decode; fixed priority only matters if the reader breaks one-at-a-time use
    always_comb begin
        if (!gal_sync_reg[1]) begin
            sel = dual_counter_pkg::SEL_A_LOW;
        end else if (!gau_sync_reg[1]) begin
            sel = dual_counter_pkg::SEL_A_HIGH;
        end else if (!gbl_sync_reg[1]) begin
            sel = dual_counter_pkg::SEL_B_LOW;
        end else if (!gbu_sync_reg[1]) begin
            sel = dual_counter_pkg::SEL_B_HIGH;
        end else begin
            sel = dual_counter_pkg::SEL_NONE;
        end
    end

    always_comb begin
        case (sel)
            dual_counter_pkg::SEL_A_LOW: begin
                y_next = pick_byte(snap_a_reg, dual_counter_pkg::LOW_LSB);
            end
            dual_counter_pkg::SEL_A_HIGH: begin
                y_next = pick_byte(snap_a_reg, dual_counter_pkg::HIGH_LSB);
            end
            dual_counter_pkg::SEL_B_LOW: begin
                y_next = pick_byte(snap_b_reg, dual_counter_pkg::LOW_LSB);
            end
            dual_counter_pkg::SEL_B_HIGH: begin
                y_next = pick_byte(snap_b_reg, dual_counter_pkg::HIGH_LSB);
            end
            default: begin
                y_next = dual_counter_pkg::BYTE_ZERO;
            end
        endcase
    end

    // released only while no gate is low
    assign y_oe_n_next = (sel == dual_counter_pkg::SEL_NONE);

    // registered byte lane
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_Y <= dual_counter_pkg::BYTE_ZERO;
        end else begin
            O_Y <= y_next;
        end
    end

    // registered enable, low while a byte is driven
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_Y_OE_N <= 1'b1;
        end else begin
            O_Y_OE_N <= y_oe_n_next;
        end
    end

endmodule : dual_counter_snapshot_reader

// file: verif/dual_counter_snapshot_reader_monitor.sv
`timescale 1ns/1ps
module dual_counter_snapshot_reader_monitor (
    // watched pins
    input wire logic       I_CLK,
    input wire logic       I_SYS_RST,
    input wire logic       I_COUNTERS_ASYNC_RESET_N,
    input wire logic       I_SEL_A_LOW_BYTE_N,
    input wire logic       I_SEL_A_HIGH_BYTE_N,
    input wire logic       I_SEL_B_LOW_BYTE_N,
    input wire logic       I_SEL_B_HIGH_BYTE_N,
    input wire logic [7:0] O_Y,
    input wire logic       O_Y_OE_N,
    input wire logic       O_COUNTER_A_TERMINAL_N
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);
    wire idle = I_SEL_A_LOW_BYTE_N & I_SEL_A_HIGH_BYTE_N &
                I_SEL_B_LOW_BYTE_N & I_SEL_B_HIGH_BYTE_N;
    property p_al_on; $fell(I_SEL_A_LOW_BYTE_N) |-> ##3 !O_Y_OE_N; endproperty
    a_al_on: assert property (p_al_on) else $error("a low gate not driven");
    property p_ah_on; !I_SEL_A_HIGH_BYTE_N [*3] |=> !O_Y_OE_N; endproperty
    a_ah_on: assert property (p_ah_on) else $error("a high gate not driven");
    property p_bl_on; !I_SEL_B_LOW_BYTE_N [*3] |=> !O_Y_OE_N; endproperty
    a_bl_on: assert property (p_bl_on) else $error("b low gate not driven");
    property p_bh_on; !I_SEL_B_HIGH_BYTE_N [*3] |=> !O_Y_OE_N; endproperty
    a_bh_on: assert property (p_bh_on) else $error("b high gate not driven");
    property p_off; $rose(I_SEL_A_LOW_BYTE_N) && idle |-> ##3 O_Y_OE_N; endproperty
    a_off: assert property (p_off) else $error("bus not released");
    property p_idle; idle [*3] |=> O_Y_OE_N; endproperty
    a_idle: assert property (p_idle) else $error("bus driven while idle");
    property p_y_zero; O_Y_OE_N |-> O_Y == 8'h00; endproperty
    a_y_zero: assert property (p_y_zero) else $error("data while released");
    property p_clr; !I_COUNTERS_ASYNC_RESET_N |-> O_COUNTER_A_TERMINAL_N; endproperty
    a_clr: assert property (p_clr) else $error("flag low during clear");
endmodule : dual_counter_snapshot_reader_monitor

bind dual_counter_snapshot_reader dual_counter_snapshot_reader_monitor i_mon (.I_CLK, .I_SYS_RST,
    .I_COUNTERS_ASYNC_RESET_N, .I_SEL_A_LOW_BYTE_N, .I_SEL_A_HIGH_BYTE_N, .I_SEL_B_LOW_BYTE_N,
    .I_SEL_B_HIGH_BYTE_N, .O_Y, .O_Y_OE_N, .O_COUNTER_A_TERMINAL_N);

// file: verif/snapshot_reader_model.sv
`timescale 1ns/1ps
module snapshot_reader_model (
    // system
    input  wire logic       i_clk,
    // read bus
    input  wire logic [7:0] i_y,
    input  wire logic       i_y_oe_n,
    output logic      [3:0] o_gate_n
);
    logic [3:0] gate_n_reg = 4'hF;
    assign o_gate_n = gate_n_reg;
    task automatic read_byte(input int idx, output logic [7:0] val);
        @(posedge i_clk);
        #1 gate_n_reg[idx] = 1'b0;
        repeat (4) @(posedge i_clk);
        // a released bus reads back as the inverse, so an unopened gate is caught
        #1 val = i_y_oe_n ? ~i_y : i_y;
        gate_n_reg = 4'hF;
        repeat (4) @(posedge i_clk);
        #1;
    endtask : read_byte
endmodule : snapshot_reader_model

// file: verif/dual_counter_snapshot_reader_tb.sv
`timescale 1ns/1ps
module dual_counter_snapshot_reader_tb;
    logic        clk = 1'b0, rst = 1'b1, cka = 1'b0, ckb = 1'b0, enb_n = 1'b1, clr_n = 1'b1;
    logic        rck = 1'b0, oe_n, term_n;
    logic [3:0]  gate_n;
    logic [7:0]  y;
    logic        chain = 1'b0;
    wire         enb_pin = chain ? term_n : enb_n;
    logic [31:0] seed = 32'h00013B77;
    int          num_errors = 0, n_tests = 0, ea = 0, eb = 0;
    int          snap_q [$];
    always #5 clk = ~clk;
    dual_counter_snapshot_reader i_dual_counter_snapshot_reader (.I_CLK(clk), .I_SYS_RST(rst),
        .I_COUNT_CLOCK_A(cka), .I_COUNT_CLOCK_B(ckb), .I_COUNTER_B_ENABLE_N(enb_pin),
        .I_COUNTERS_ASYNC_RESET_N(clr_n), .O_COUNTER_A_TERMINAL_N(term_n),
        .I_REGISTER_CLOCK(rck), .I_SEL_A_LOW_BYTE_N(gate_n[0]), .I_SEL_A_HIGH_BYTE_N(gate_n[1]),
        .I_SEL_B_LOW_BYTE_N(gate_n[2]), .I_SEL_B_HIGH_BYTE_N(gate_n[3]), .O_Y(y), .O_Y_OE_N(oe_n));
    snapshot_reader_model i_snapshot_reader_model (.i_clk(clk), .i_y(y), .i_y_oe_n(oe_n),
        .o_gate_n(gate_n));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic edges(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : edges
    // 2 cycles high, 2 low; the model counts only what the pins allow
    task automatic pulse(input int b, input int n);
        repeat (n) begin
            if (b) ckb = 1'b1; else cka = 1'b1;
            if (!clr_n) ; else if (!b) ea++; else if (!enb_pin) eb++;
            edges(2);
            cka = 1'b0;
            ckb = 1'b0;
            edges(2);
        end
    endtask : pulse
    task automatic capture();
        rck = 1'b1;
        snap_q.push_back(ea);
        snap_q.push_back(eb);
        edges(2);
        rck = 1'b0;
        edges(4);
    endtask : capture
    task automatic readback();
        logic [7:0] b [4];
        for (int i = 0; i < 4; i++) i_snapshot_reader_model.read_byte(i, b[i]);
        check({b[1], b[0]}, 16'(snap_q.pop_front()));
        check({b[3], b[2]}, 16'(snap_q.pop_front()));
    endtask : readback
    task automatic end_sim();
        if (num_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim
    initial begin
        #100000;
        num_errors++;
        end_sim();
    end
    initial begin
        edges(2);
        rst = 1'b0;
        edges(1);
        capture();
        readback();
        for (int k = 0; k < 4; k++) begin
            enb_n = 1'(rnd());
            pulse(0, 1 + int'(rnd() % 40));
            pulse(1, 1 + int'(rnd() % 20));
            check(16'(term_n), 16'h0001);
            capture();
            readback();
        end
        // clear leaves the snapshot alone, so the old counts read back
        capture();
        clr_n = 1'b0;
        edges(1);
        check(16'(term_n), 16'h0001);
        pulse(0, 2);
        clr_n = 1'b1;
        ea = 0;
        eb = 0;
        edges(3);
        readback();
        enb_n = 1'b0;
        pulse(0, 3);
        pulse(1, 2);
        capture();
        readback();
        // chained: b enable follows the a flag, high below full count
        chain = 1'b1;
        pulse(0, 2);
        pulse(1, 2);
        capture();
        readback();
        end_sim();
    end
endmodule : dual_counter_snapshot_reader_tb
